/* File: rtl/rst_init_pkg.sv */
// constants shared by the reset and initialisation sequencer
// assumes a single 100 MHz system clock
package rst_init_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXT_INIT_TIME_NS = 1000;
  localparam int SW_INIT_TIME_NS = 1000;
  localparam int SW_INIT_NONMUX_TIME_NS = 2000;
  localparam int TIMER_W = 8;
  // durations round down; a time under one cycle gives zero
  localparam logic [TIMER_W-1:0] EXT_INIT_CYC = TIMER_W'(EXT_INIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SW_INIT_CYC = TIMER_W'(SW_INIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SW_INIT_NONMUX_CYC =
    TIMER_W'(SW_INIT_NONMUX_TIME_NS / CLK_PERIOD_NS);

  // ************************************************************
  // channels and reset values
  // ************************************************************
  localparam int NUM_CHAN = 4;
  localparam int SYNC_W = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 4'h0;

  typedef enum logic [2:0] {
    ST_POR,
    ST_FROZEN,
    ST_INIT,
    ST_SW_INIT,
    ST_READY
  } init_state_t;

endpackage : rst_init_pkg

/* File: rtl/sync2.sv */
// two-flop synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk_i
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : sync2

/* File: rtl/cycle_timer.sv */
// down-counting cycle timer with a one-cycle done pulse
// assumes load_i and load_val_i come from logic on clk_i
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  // status
  output logic done_o
);

  logic [W-1:0] count_ff;
  logic done_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_ff <= '0;
    end else if (load_i) begin
      count_ff <= load_val_i;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - W'(1);
    end
  end

  // a reload cancels a pending expiry
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= !load_i && (count_ff == W'(1));
    end
  end

  assign done_o = done_ff;

endmodule : cycle_timer

/* File: rtl/quad_line_unit_reset_init.sv */
// reset, initialisation and reference clock gating for a four-channel line unit
// assumes pins arrive asynchronously; the init strobe and clock-activity flags are on clk_i
`timescale 1ns/1ps

// Summary of operation
// - each port's transmitter runs from its own transmit timing clock
// - clock recovery is offered only while the receive reference clock is present
// - with no reference clock the unit still works as an analog front end
// - all four recovery circuits take the one common receive reference
// - configuration comes from dedicated pins or from the host port
// - power-up reset loads defaults and clears no-signal detectors
// - while the external reset pin is low the unit stays frozen
// - the external reset returns every register to its default
// - a software init trigger starts a one microsecond reset cycle
// - in non-multiplexed parallel bus mode the software cycle lasts two microseconds
// - initialisation ends one microsecond after the reset pin rises
module quad_line_unit_reset_init
  import rst_init_pkg::*;
#(
  parameter int CHANNELS = rst_init_pkg::NUM_CHAN
) (
  // clock and power-up reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic ext_rst_n_i,
  input wire logic host_mode_i,
  input wire logic nonmux_bus_i,
  input wire logic rx_ref_present_i,
  // host and clock-activity inputs on clk_i
  input wire logic software_init_trigger_i,
  input wire logic recovery_req_i,
  input wire logic [CHANNELS-1:0] transmit_timing_clock_active_i,
  // reset state
  output logic reg_default_load_o,
  output logic no_signal_detect_clr_o,
  output logic frozen_o,
  output logic ready_o,
  output logic host_cfg_sel_o,
  // reference clock routing
  output logic [CHANNELS-1:0] tx_ref_en_o,
  output logic [CHANNELS-1:0] rx_ref_route_o,
  output logic recovery_avail_o,
  output logic data_recovery_mode_o
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] pin_sync;
  logic ext_rst_n_sync;
  logic host_mode_sync;
  logic nonmux_sync;
  logic ref_sync;

  // the reset pin is seen low until it has crossed both flops
  sync2 #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST_VAL)
  ) u_pin_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({rx_ref_present_i, nonmux_bus_i, host_mode_i, ext_rst_n_i}),
    .sync_o(pin_sync)
  );

  assign ext_rst_n_sync = pin_sync[0];
  assign host_mode_sync = pin_sync[1];
  assign nonmux_sync = pin_sync[2];
  assign ref_sync = pin_sync[3];

  // ************************************************************
  // sequencer
  // ************************************************************
  init_state_t state_ff;
  init_state_t nxt_state;
  logic timer_load;
  logic [TIMER_W-1:0] timer_val;
  logic timer_done;
  logic sw_start;
  logic por_ff;
  logic nxt_ready;

  // software trigger only acts once the unit is running
  assign sw_start = (state_ff == ST_READY) && software_init_trigger_i;

  always_comb begin
    nxt_state = state_ff;
    if (!ext_rst_n_sync) begin
      nxt_state = ST_FROZEN;
    end else begin
      unique case (state_ff)
        ST_POR: begin
          nxt_state = ST_INIT;
        end
        ST_FROZEN: begin
          nxt_state = ST_INIT;
        end
        ST_INIT: begin
          if (timer_done) begin
            nxt_state = ST_READY;
          end
        end
        ST_SW_INIT: begin
          if (timer_done) begin
            nxt_state = ST_READY;
          end
        end
        ST_READY: begin
          if (sw_start) begin
            nxt_state = ST_SW_INIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // timer is loaded on entry to a timed state
  assign timer_load = ((nxt_state == ST_INIT) && (state_ff != ST_INIT)) ||
                      ((nxt_state == ST_SW_INIT) && (state_ff != ST_SW_INIT));

  always_comb begin
    timer_val = EXT_INIT_CYC;
    if (nxt_state == ST_SW_INIT) begin
      timer_val = nonmux_sync ? SW_INIT_NONMUX_CYC : SW_INIT_CYC;
    end
  end

  cycle_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(timer_load),
    .load_val_i(timer_val),
    .done_o(timer_done)
  );

  assign nxt_ready = (nxt_state == ST_READY);

  // power-up marker lasts until the first completed initialisation
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      por_ff <= 1'b1;
    end else if (nxt_ready) begin
      por_ff <= 1'b0;
    end
  end

  // ************************************************************
  // reset outputs
  // ************************************************************
  // registers sit at defaults in every state but ready
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_default_load_o <= 1'b1;
    end else begin
      reg_default_load_o <= !nxt_ready;
    end
  end

  // detector clear belongs to the power-up sequence only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      no_signal_detect_clr_o <= 1'b1;
    end else begin
      no_signal_detect_clr_o <= por_ff && !nxt_ready;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      frozen_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      frozen_o <= (nxt_state == ST_FROZEN);
      ready_o <= nxt_ready;
    end
  end

  // the strap is followed whenever ready_o is low, frozen included, and held while ready
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      host_cfg_sel_o <= 1'b0;
    end else if (!ready_o) begin
      host_cfg_sel_o <= host_mode_sync;
    end
  end

  // ************************************************************
  // reference clock routing
  // ************************************************************
  logic nxt_recovery;

  // recovery needs the shared reference; without it the unit is a plain front end
  assign nxt_recovery = nxt_ready && recovery_req_i && ref_sync;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      recovery_avail_o <= 1'b0;
      data_recovery_mode_o <= 1'b0;
    end else begin
      recovery_avail_o <= nxt_recovery;
      data_recovery_mode_o <= nxt_ready && !nxt_recovery;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          tx_ref_en_o[ch] <= 1'b0;
          rx_ref_route_o[ch] <= 1'b0;
        end else begin
          tx_ref_en_o[ch] <= nxt_ready && transmit_timing_clock_active_i[ch];
          rx_ref_route_o[ch] <= nxt_recovery;
        end
      end
    end
  endgenerate

  // ************************************************************
  // checks
  // ************************************************************
  logic [TIMER_W-1:0] dur_ff;
  logic [TIMER_W-1:0] exp_ff;
  logic timed_exit;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dur_ff <= '0;
      exp_ff <= '0;
    end else begin
      dur_ff <= (timer_load || state_ff == ST_READY) ? '0 : dur_ff + TIMER_W'(1);
      if (timer_load) begin
        exp_ff <= timer_val;
      end
    end
  end

  assign timed_exit = (state_ff inside {ST_INIT, ST_SW_INIT}) && (nxt_state == ST_READY);

  sequence s_pin_low;
    !ext_rst_n_sync;
  endsequence

  sequence s_sw_request;
    ready_o && software_init_trigger_i && ext_rst_n_sync;
  endsequence

  a_frozen_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pin_low |=> frozen_o && !ready_o && reg_default_load_o)
    else $error("unit not frozen while reset pin low");

  a_ext_defaults: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frozen_o |-> reg_default_load_o && !tx_ref_en_o[0])
    else $error("registers released during external reset");

  a_ext_init_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timed_exit && state_ff == ST_INIT |-> dur_ff == EXT_INIT_CYC)
    else $error("external init length wrong");

  a_sw_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_sw_request |=> !ready_o && reg_default_load_o ##1 state_ff == ST_SW_INIT)
    else $error("software init did not start");

  a_sw_init_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timed_exit && state_ff == ST_SW_INIT |-> dur_ff == exp_ff &&
      (exp_ff == SW_INIT_CYC || exp_ff == SW_INIT_NONMUX_CYC))
    else $error("software init length wrong");

  a_nonmux_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_sw_request and nonmux_sync) ##1 ext_rst_n_sync [*2]
      |-> exp_ff == SW_INIT_NONMUX_CYC)
    else $error("non-multiplexed init length wrong");

  a_por_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> no_signal_detect_clr_o && reg_default_load_o
      ##1 no_signal_detect_clr_o && reg_default_load_o && !ready_o)
    else $error("power-up did not clear detectors");

  a_tx_ref_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_ref_en_o != '0 |-> ready_o &&
      (tx_ref_en_o & ~$past(transmit_timing_clock_active_i)) == '0)
    else $error("transmitter enabled without its clock");

  a_recovery_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    recovery_avail_o |-> $past(ref_sync) && $past(recovery_req_i))
    else $error("recovery offered without reference");

  a_afe_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ready_o |-> data_recovery_mode_o != recovery_avail_o)
    else $error("front-end mode and recovery disagree");

  a_common_ref: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_ref_route_o == {CHANNELS{recovery_avail_o}})
    else $error("channels use different references");

  a_cfg_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ready_o && $past(ready_o) |-> $stable(host_cfg_sel_o))
    else $error("configuration source changed while running");

  a_pin_sync_lag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(ext_rst_n_sync) && frozen_o |=> !ready_o [*2])
    else $error("released before synchronised init");

endmodule : quad_line_unit_reset_init

/* File: verif/board_host_model.sv */
// board reset logic and host write strobe driving the sequencer
// assumes the bench raises requests after a falling edge of clk_i
`timescale 1ns/1ps
module board_host_model (
  // clock
  input wire logic clk_i,
  // requests from the bench
  input wire logic pin_low_req_i,
  input wire logic trig_req_i,
  input wire logic ref_on_i,
  input wire logic ready_i,
  // pins toward the device
  output logic ext_rst_n_o,
  output logic init_trigger_o,
  output logic rx_ref_present_o
);
  // ************************************************************
  // pin and strobe drivers
  // ************************************************************
  initial begin
    ext_rst_n_o = 1'b1;
    init_trigger_o = 1'b0;
    rx_ref_present_o = 1'b0;
  end
  always @(negedge clk_i) begin
    ext_rst_n_o <= !pin_low_req_i;
    rx_ref_present_o <= ref_on_i;
    // the host only writes the trigger while the unit is ready
    init_trigger_o <= trig_req_i && ready_i && !init_trigger_o;
  end
endmodule : board_host_model

/* File: verif/tb_quad_line_unit_reset_init.sv */
// self-checking bench for the reset and initialisation sequencer
// assumes a 100 MHz clk_i and the cycle counts of rst_init_pkg
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((ex) !== (got)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_quad_line_unit_reset_init;
  import rst_init_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk_i, sys_rst_i, ext_rst_n_i, host_mode_i, nonmux_bus_i, rx_ref_present_i;
  logic software_init_trigger_i, recovery_req_i;
  logic [3:0] transmit_timing_clock_active_i, tx_ref_en_o, rx_ref_route_o;
  logic reg_default_load_o, no_signal_detect_clr_o, frozen_o, ready_o, host_cfg_sel_o;
  logic recovery_avail_o, data_recovery_mode_o;
  logic pin_low_req, trig_req, ref_on, rr, prev_ready;
  int err_total, checked, seed, cnt, lo, hi;
  int lo_q[$];
  int hi_q[$];
  quad_line_unit_reset_init quad_line_unit_reset_init_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .ext_rst_n_i(ext_rst_n_i), .host_mode_i(host_mode_i),
    .nonmux_bus_i(nonmux_bus_i), .rx_ref_present_i(rx_ref_present_i),
    .software_init_trigger_i(software_init_trigger_i), .recovery_req_i(recovery_req_i),
    .transmit_timing_clock_active_i(transmit_timing_clock_active_i),
    .reg_default_load_o(reg_default_load_o), .no_signal_detect_clr_o(no_signal_detect_clr_o),
    .frozen_o(frozen_o), .ready_o(ready_o), .host_cfg_sel_o(host_cfg_sel_o),
    .tx_ref_en_o(tx_ref_en_o), .rx_ref_route_o(rx_ref_route_o),
    .recovery_avail_o(recovery_avail_o), .data_recovery_mode_o(data_recovery_mode_o));
  board_host_model board_host_model_inst (.clk_i(clk_i), .pin_low_req_i(pin_low_req),
    .trig_req_i(trig_req), .ref_on_i(ref_on), .ready_i(ready_o), .ext_rst_n_o(ext_rst_n_i),
    .init_trigger_o(software_init_trigger_i), .rx_ref_present_o(rx_ref_present_i));
  // ************************************************************
  // clock, closing and watchdog
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
  // ************************************************************
  // monitor: low span of ready after reset, freeze or ready, against oldest note
  // ************************************************************
  always @(posedge clk_i) begin
    prev_ready <= ready_o;
    if (sys_rst_i || frozen_o || ready_o) cnt <= 0;
    else cnt <= cnt + 1;
    if (ready_o === 1'b1 && prev_ready === 1'b0) begin
      if (lo_q.size() == 0) `CHK("unexpected ready", 0, 1)
      else begin
        lo = lo_q.pop_front();
        hi = hi_q.pop_front();
        // counts round down to whole cycles, so spans are compared in cycles
        `CHK($sformatf("ready low span %0d", cnt), 1'b1, (cnt >= lo && cnt <= hi))
      end
    end
  end
  // ************************************************************
  // stimulus
  // ************************************************************
  task automatic note(input int l, input int h);
    lo_q.push_back(l);
    hi_q.push_back(h);
  endtask : note
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    // a ready that never comes is a failure, not a silent timeout
    if (n >= 400) err_total++;
    @(negedge clk_i);
  endtask : wait_ready
  task automatic sw_init(input logic nm, input int span);
    nonmux_bus_i = nm;
    repeat (4) @(negedge clk_i);
    note(span, span);
    // requests to the model change by nba so its negedge sampling never races
    trig_req <= 1'b1;
    @(negedge clk_i);
    trig_req <= 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("sw ready", 1'b0, ready_o)
    `CHK("sw defaults", 1'b1, reg_default_load_o)
    `CHK("sw tx off", 4'h0, tx_ref_en_o)
    wait_ready();
  endtask : sw_init
  initial begin
    seed = 32'h00dbe248;
    sys_rst_i = 1'b1;
    pin_low_req = 1'b0;
    trig_req = 1'b0;
    ref_on = 1'b0;
    nonmux_bus_i = 1'b0;
    recovery_req_i = 1'b0;
    transmit_timing_clock_active_i = 4'h0;
    host_mode_i = 1'($random(seed));
    repeat (5) @(negedge clk_i);
    note(100, 104);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    `CHK("por clear", 1'b1, no_signal_detect_clr_o)
    `CHK("por defaults", 1'b1, reg_default_load_o)
    wait_ready();
    `CHK("cfg source", host_mode_i, host_cfg_sel_o)
    `CHK("clear ends", 1'b0, no_signal_detect_clr_o)
    `CHK("defaults end", 1'b0, reg_default_load_o)
    // random clock activity, reference presence and recovery requests
    for (int i = 0; i < 12; i++) begin
      transmit_timing_clock_active_i = 4'($random(seed));
      recovery_req_i = 1'($random(seed));
      ref_on <= 1'($random(seed));
      repeat (5) @(negedge clk_i);
      rr = recovery_req_i & ref_on;
      `CHK("tx ref", transmit_timing_clock_active_i, tx_ref_en_o)
      `CHK("rx route", {4{rr}}, rx_ref_route_o)
      `CHK("recovery", rr, recovery_avail_o)
      `CHK("front end", !rr, data_recovery_mode_o)
    end
    sw_init(1'b0, 101);
    sw_init(1'b1, 201);
    // override reset held for a while, then released
    note(100, 104);
    pin_low_req <= 1'b1;
    repeat (5) @(negedge clk_i);
    `CHK("frozen", 1'b1, frozen_o)
    `CHK("pin ready", 1'b0, ready_o)
    `CHK("pin defaults", 1'b1, reg_default_load_o)
    `CHK("pin recovery", 1'b0, recovery_avail_o)
    repeat (10) @(negedge clk_i);
    `CHK("still frozen", 1'b1, frozen_o)
    pin_low_req <= 1'b0;
    wait_ready();
    `CHK("thawed", 1'b0, frozen_o)
    `CHK("pin no clear", 1'b0, no_signal_detect_clr_o)
    repeat (6) @(negedge clk_i);
    `CHK("notes left", 0, lo_q.size())
    tally_and_finish();
  end
endmodule : tb_quad_line_unit_reset_init
